/* rtl/lfd_regs.sv */
// fault flags, failsafe output, dimming and OTP registers over AXI4-Lite
// assumes fault and headroom inputs come asynchronously from analog pins,
// and the otp_* inputs hold still from reset release onward
module lfd_regs (
   input  wire logic                      clock,
   input  wire logic                      reset,
   // AXI4-Lite slave
   input  wire logic [lfd_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [lfd_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   // fault conditions from the analog side
   input  wire logic [15:0]               channel_short_cond,
   input  wire logic                      overtemp_warning_cond,
   input  wire logic                      thermal_shutdown_cond,
   input  wire logic                      current_set_short_cond,
   input  wire logic                      current_set_open_cond,
   input  wire logic                      enable_pin,
   input  wire logic                      headroom_low,
   input  wire logic                      headroom_high,
   // OTP contents
   input  wire logic [7:0]                otp_setpoint_code,
   input  wire logic [2:0]                otp_low_band,
   input  wire logic [2:0]                otp_high_band,
   input  wire logic [7:0]                otp_suffix,
   input  wire logic                      otp_address_page_bit,
   // outputs to the channels and the pin
   output logic [lfd_pkg::NCH*lfd_pkg::DUTY_W-1:0]  duty_value,
   output logic [lfd_pkg::NCH*lfd_pkg::LEVEL_W-1:0] current_level_value,
   output logic                           failsafe_out_n
);
   typedef struct packed {
      logic [lfd_pkg::SYNC_W-1:0] sync1;
      logic [lfd_pkg::SYNC_W-1:0] sync2;
      logic        otp_loaded;
      logic [7:0]  setpoint_code;
      logic [2:0]  low_band;
      logic [2:0]  high_band;
      logic [7:0]  suffix;
      logic        page;
      logic [15:0] ctrl;
      logic [15:0] short_flags;
      logic [15:0] prot_flags;
      logic        current_set_pin_latched;
      logic [lfd_pkg::NCH-1:0][lfd_pkg::DUTY_W-1:0]  duty;
      logic [lfd_pkg::NCH-1:0][lfd_pkg::LEVEL_W-1:0] level;
      logic        aw_held;
      logic        w_held;
      logic [5:0]  aw_idx;
      logic [31:0] wdata;
      logic [3:0]  wstrb;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [1:0]  rresp;
      logic [31:0] rdata;
      logic        failsafe_n;
   } lfd_state_t;

   lfd_state_t st;
   lfd_state_t next_st;
   lfd_loop_if loop_bus ();

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   // byte-lane merge of a 16-bit register; upper lanes carry nothing
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0]  strb);
      logic [15:0] r;
      r = old;
      if (strb[0]) begin
         r[7:0] = data[7:0];
      end
      if (strb[1]) begin
         r[15:8] = data[15:8];
      end
      return r;
   endfunction : merge16

   // read mux: bit 32 flags a mapped index, bits 31:0 the word
   function automatic logic [32:0] read_word(input lfd_state_t s,
                                             input logic [5:0] idx,
                                             input logic [7:0] live);
      logic [5:0]  off;
      logic [32:0] r;
      off = 6'h00;
      r   = {1'b1, 32'h0000_0000};
      if (idx >= lfd_pkg::IDX_DUTY0 && idx <= lfd_pkg::IDX_DUTY15) begin
         off = idx - lfd_pkg::IDX_DUTY0;
         r[11:0] = s.duty[off[3:0]];
      end else if (idx >= lfd_pkg::IDX_LEVEL0 &&
                   idx <= lfd_pkg::IDX_LEVEL15) begin
         off = idx - lfd_pkg::IDX_LEVEL0;
         r[5:0] = s.level[off[3:0]];
      end else begin
         unique case (idx)
            lfd_pkg::IDX_CTRL:     r[15:0] = s.ctrl;
            lfd_pkg::IDX_SHORT:    r[15:0] = s.short_flags;
            lfd_pkg::IDX_PROT:     r[15:0] = s.prot_flags;
            lfd_pkg::IDX_SETPOINT: r[15:0] = {s.setpoint_code, live};
            lfd_pkg::IDX_BAND:     r[15:0] = {lfd_pkg::BAND_UPPER,
                                              s.low_band, s.high_band,
                                              lfd_pkg::BAND_FILL};
            lfd_pkg::IDX_SUFFIX:   r[7:0] = s.suffix;
            lfd_pkg::IDX_PAGE:     r[lfd_pkg::PAGE_BIT] = s.page;
            default:               r = {1'b0, 32'h0000_0000};
         endcase
      end
      return r;
   endfunction : read_word

   // -----------------------------------------------------------------
   // next-state logic
   // -----------------------------------------------------------------
   logic        aw_take;
   logic        w_take;
   logic        ar_take;
   logic        do_write;
   logic [32:0] rd;
   logic [5:0]  woff;
   logic [15:0] clr_short;
   logic [15:0] clr_prot;
   logic [15:0] set_prot;
   logic [15:0] cond_short;
   logic        ch_pending;
   logic        fault_any;

   assign s_axi_awready = !st.aw_held && !st.bvalid;
   assign s_axi_wready  = !st.w_held && !st.bvalid;
   assign s_axi_arready = !st.rvalid;
   assign aw_take  = s_axi_awvalid && s_axi_awready;
   assign w_take   = s_axi_wvalid && s_axi_wready;
   assign ar_take  = s_axi_arvalid && s_axi_arready;
   assign do_write = st.aw_held && st.w_held && !st.bvalid;
   assign cond_short = st.sync2[15:0];

   always_comb begin
      next_st   = st;
      rd        = read_word(st, s_axi_araddr[7:2], loop_bus.count);
      woff      = 6'h00;
      clr_short = 16'h0000;
      clr_prot  = 16'h0000;
      // two flops on every asynchronous pin; only sync2 is read below
      next_st.sync1 = {headroom_high, headroom_low, enable_pin,
                       current_set_open_cond, current_set_short_cond,
                       thermal_shutdown_cond, overtemp_warning_cond,
                       channel_short_cond};
      next_st.sync2 = st.sync1;

      // OTP image is caught once, on the first cycle after reset
      if (!st.otp_loaded) begin
         next_st.otp_loaded    = 1'b1;
         next_st.setpoint_code = otp_setpoint_code;
         next_st.low_band      = otp_low_band;
         next_st.high_band     = otp_high_band;
         next_st.suffix        = otp_suffix;
         next_st.page          = otp_address_page_bit;
      end

      // write channel: address and data taken in either order
      if (aw_take) begin
         next_st.aw_held = 1'b1;
         next_st.aw_idx  = s_axi_awaddr[7:2];
      end
      if (w_take) begin
         next_st.w_held = 1'b1;
         next_st.wdata  = s_axi_wdata;
         next_st.wstrb  = s_axi_wstrb;
      end
      if (do_write) begin
         next_st.aw_held = 1'b0;
         next_st.w_held  = 1'b0;
         next_st.bvalid  = 1'b1;
         next_st.bresp   = lfd_pkg::RESP_OKAY;
         if (st.aw_idx >= lfd_pkg::IDX_DUTY0 &&
             st.aw_idx <= lfd_pkg::IDX_DUTY15) begin
            woff = st.aw_idx - lfd_pkg::IDX_DUTY0;
            next_st.duty[woff[3:0]] = 12'(merge16({4'h0, st.duty[woff[3:0]]},
                                      st.wdata, st.wstrb));
         end else if (st.aw_idx >= lfd_pkg::IDX_LEVEL0 &&
                      st.aw_idx <= lfd_pkg::IDX_LEVEL15) begin
            woff = st.aw_idx - lfd_pkg::IDX_LEVEL0;
            next_st.level[woff[3:0]] = 6'(merge16({10'h000,
                                       st.level[woff[3:0]]},
                                       st.wdata, st.wstrb));
         end else if (st.aw_idx == lfd_pkg::IDX_CTRL) begin
            // only mode, masks and loop enable are writable
            next_st.ctrl = merge16(st.ctrl, st.wdata, st.wstrb)
                           & lfd_pkg::CTRL_WMASK;
         end else if (!1'(read_word(st, st.aw_idx, 8'h00) >> 32)) begin
            next_st.bresp = lfd_pkg::RESP_SLVERR;
         end
         // writes to flag and OTP registers are ignored with OKAY
      end
      if (st.bvalid && s_axi_bready) begin
         next_st.bvalid = 1'b0;
      end

      // read channel; a read of a flag register clears what it returned
      if (ar_take) begin
         next_st.rvalid = 1'b1;
         next_st.rdata  = rd[31:0];
         next_st.rresp  = rd[32] ? lfd_pkg::RESP_OKAY : lfd_pkg::RESP_SLVERR;
         if (s_axi_araddr[7:2] == lfd_pkg::IDX_SHORT) begin
            clr_short = st.short_flags;
         end
         if (s_axi_araddr[7:2] == lfd_pkg::IDX_PROT) begin
            clr_prot = st.prot_flags;
         end
      end else if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end

      // a fault still present sets its flag again, so set beats clear;
      // in hiccup mode this keeps the flag until the fault is removed
      next_st.short_flags = cond_short
                            | (st.short_flags & ~clr_short);
      set_prot = 16'h0000;
      set_prot[lfd_pkg::PROT_OTW_BIT] = st.sync2[lfd_pkg::S_OTW];
      set_prot[lfd_pkg::PROT_ISS_BIT] = st.sync2[lfd_pkg::S_ISS];
      set_prot[lfd_pkg::PROT_ISO_BIT] = st.sync2[lfd_pkg::S_ISO];
      set_prot[lfd_pkg::PROT_TSD_BIT] = st.sync2[lfd_pkg::S_TSD];
      next_st.prot_flags = set_prot | (st.prot_flags & ~clr_prot);

      // current-set faults hold the failsafe until enable drops low
      next_st.current_set_pin_latched = st.sync2[lfd_pkg::S_ISS]
                             | st.sync2[lfd_pkg::S_ISO]
                             | (st.current_set_pin_latched
                                & st.sync2[lfd_pkg::S_EN]);

      // latch-off releases on the read, hiccup only when the fault goes
      ch_pending = st.ctrl[lfd_pkg::CTRL_LATCH_BIT] ? (|st.short_flags)
                                                     : (|cond_short);
      fault_any = (ch_pending && !st.ctrl[lfd_pkg::CTRL_MASK_BIT])
                  || (st.sync2[lfd_pkg::S_OTW]
                      && !st.ctrl[lfd_pkg::CTRL_OTWM_BIT])
                  || st.sync2[lfd_pkg::S_TSD]
                  || st.current_set_pin_latched;
      next_st.failsafe_n = !fault_any;

      // synchronous reset stands for loss of the supply rail
      if (reset) begin
         next_st = '0;
         next_st.ctrl          = lfd_pkg::CTRL_RESET;
         next_st.setpoint_code = lfd_pkg::SETPOINT_RESET;
         next_st.low_band      = lfd_pkg::LOW_BAND_RESET;
         next_st.high_band     = lfd_pkg::HIGH_BAND_RESET;
         next_st.duty          = {lfd_pkg::NCH{lfd_pkg::DUTY_RESET}};
         next_st.level         = {lfd_pkg::NCH{lfd_pkg::LEVEL_RESET}};
         next_st.failsafe_n    = 1'b1;
      end
   end

   // -----------------------------------------------------------------
   // state register
   // -----------------------------------------------------------------
   always_ff @(posedge clock) begin
      st <= next_st;
   end

   // -----------------------------------------------------------------
   // feedback counter
   // -----------------------------------------------------------------
   // counter restarts from the OTP code when the image is loaded
   assign loop_bus.load      = !st.otp_loaded;
   assign loop_bus.load_code = otp_setpoint_code;
   assign loop_bus.enable    = st.ctrl[lfd_pkg::CTRL_LOOP_BIT];
   assign loop_bus.raise     = st.sync2[lfd_pkg::S_HRLO];
   assign loop_bus.lower     = st.sync2[lfd_pkg::S_HRHI];

   lfd_headroom_loop u_loop (
      .clock (clock),
      .reset (reset),
      .lp    (loop_bus.loop)
   );

   // -----------------------------------------------------------------
   // outputs
   // -----------------------------------------------------------------
   assign s_axi_bvalid        = st.bvalid;
   assign s_axi_bresp         = st.bresp;
   assign s_axi_rvalid        = st.rvalid;
   assign s_axi_rresp         = st.rresp;
   assign s_axi_rdata         = st.rdata;
   assign duty_value          = st.duty;
   assign current_level_value = st.level;
   assign failsafe_out_n      = st.failsafe_n;
endmodule : lfd_regs

/* inc/lfd_pkg.sv */
// constants shared by the fault, dimming and headroom register bank
// assumes a 100 MHz clock, an AXI4-Lite master and OTP values held static
// Summary of operation
// - sixteen channel short flags, bit 15 is channel 16; one read clears them.
// - latch-off clears flag and failsafe on read; hiccup holds both while fault.
// - protection flags set on their trigger and clear after one read.
// - warning at bit 14, clears on read, failsafe recovers with temperature.
// - current-set short at bit 13, failsafe released only by reset or enable.
// - current-set open at bit 12, failsafe held until reset or enable low.
// - thermal shutdown at bit 10, clears on read, failsafe recovers with it.
// - sixteen read/write 12-bit duty registers, 0x07 to 0x16, default 0xFFF.
// - sixteen read/write 6-bit level registers, 0x17 to 0x26, default 0x20.
// - setpoint upper byte read-only OTP code, 14 to 244, default 0x54.
// - setpoint lower byte returns the live feedback counter value.
// - feedback counter steps up or down following channel headroom.
// - band bits 7 to 5 read-only low band, default code 0b101.
// - band bits 4 to 2 read-only high band, default code 0b110.
// - suffix register returns the read-only OTP suffix code in bits 7 to 0.
// - address page bit at bit 6, read-only, loaded from OTP.
// - mode bit 14 selects hiccup when 0, latch-off when 1; defaults latch-off.
// - channel mask bit set keeps channel faults off the failsafe output.
// - warning mask bit set keeps warnings off the failsafe output.
package lfd_pkg;
   // -----------------------------------------------------------------
   // bus and register indices (byte address is four times the index)
   // -----------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int NCH    = 16;
   localparam logic [5:0] IDX_CTRL     = 6'h02;
   localparam logic [5:0] IDX_SHORT    = 6'h05;
   localparam logic [5:0] IDX_PROT     = 6'h06;
   localparam logic [5:0] IDX_DUTY0    = 6'h07;
   localparam logic [5:0] IDX_DUTY15   = 6'h16;
   localparam logic [5:0] IDX_LEVEL0   = 6'h17;
   localparam logic [5:0] IDX_LEVEL15  = 6'h26;
   localparam logic [5:0] IDX_SETPOINT = 6'h27;
   localparam logic [5:0] IDX_BAND     = 6'h28;
   localparam logic [5:0] IDX_SUFFIX   = 6'h32;
   localparam logic [5:0] IDX_PAGE     = 6'h33;
   localparam logic [1:0] RESP_OKAY    = 2'h0;
   localparam logic [1:0] RESP_SLVERR  = 2'h2;
   // -----------------------------------------------------------------
   // field positions and reset values
   // -----------------------------------------------------------------
   localparam int PROT_OTW_BIT   = 14;
   localparam int PROT_ISS_BIT   = 13;
   localparam int PROT_ISO_BIT   = 12;
   localparam int PROT_TSD_BIT   = 10;
   localparam int CTRL_MASK_BIT  = 15;
   localparam int CTRL_LATCH_BIT = 14;
   localparam int CTRL_OTWM_BIT  = 7;
   localparam int CTRL_LOOP_BIT  = 1;
   localparam logic [15:0] CTRL_RESET = 16'h4002;
   localparam logic [15:0] CTRL_WMASK = 16'hC082;
   localparam int DUTY_W  = 12;
   localparam int LEVEL_W = 6;
   localparam logic [11:0] DUTY_RESET  = 12'hFFF;
   localparam logic [5:0]  LEVEL_RESET = 6'h20;
   localparam logic [7:0]  SETPOINT_RESET = 8'h54;
   localparam logic [7:0]  CODE_MIN = 8'h0E;
   localparam logic [7:0]  CODE_MAX = 8'hF4;
   localparam logic [7:0]  BAND_UPPER = 8'h25;
   localparam logic [2:0]  LOW_BAND_RESET  = 3'h5;
   localparam logic [2:0]  HIGH_BAND_RESET = 3'h6;
   localparam logic [1:0]  BAND_FILL = 2'h1;
   localparam int PAGE_BIT = 6;
   // -----------------------------------------------------------------
   // synchroniser vector layout
   // -----------------------------------------------------------------
   localparam int S_OTW  = 16;
   localparam int S_TSD  = 17;
   localparam int S_ISS  = 18;
   localparam int S_ISO  = 19;
   localparam int S_EN   = 20;
   localparam int S_HRLO = 21;
   localparam int S_HRHI = 22;
   localparam int SYNC_W = 23;
   // -----------------------------------------------------------------
   // timing
   // -----------------------------------------------------------------
   localparam int CLK_NS       = 10;
   localparam int LOOP_STEP_NS = 10000;
   localparam logic [9:0] LOOP_STEP_CYC = 10'(LOOP_STEP_NS / CLK_NS);
endpackage : lfd_pkg

/* inc/lfd_loop_if.sv */
// carrier between the register bank and the headroom counter
// assumes both ends run on the same clock
interface lfd_loop_if;
   logic       load;
   logic [7:0] load_code;
   logic       enable;
   logic       raise;
   logic       lower;
   logic [7:0] count;
   modport ctrl (output load, load_code, enable, raise, lower,
                 input count);
   modport loop (input load, load_code, enable, raise, lower,
                 output count);
endinterface : lfd_loop_if

/* rtl/lfd_headroom_loop.sv */
// up-down feedback counter that tracks the supply headroom
// assumes raise and lower are already synchronised to clock
module lfd_headroom_loop (
   input wire logic   clock,
   input wire logic   reset,
   lfd_loop_if.loop   lp
);
   typedef struct packed {
      logic [9:0] div;
      logic [7:0] count;
   } lfd_loop_state_t;

   lfd_loop_state_t st;
   lfd_loop_state_t next_st;
   logic            tick;

   // -----------------------------------------------------------------
   // step divider and counter
   // -----------------------------------------------------------------
   // one step per divider period keeps the external regulator stable
   always_comb begin
      next_st = st;
      tick    = (st.div == lfd_pkg::LOOP_STEP_CYC - 10'h001);
      next_st.div = tick ? 10'h000 : st.div + 10'h001;
      if (lp.load) begin
         next_st.count = lp.load_code;
      end else if (tick && lp.enable) begin
         if (lp.raise && st.count < lfd_pkg::CODE_MAX) begin
            next_st.count = st.count + 8'h01;
         end else if (lp.lower && !lp.raise &&
                      st.count > lfd_pkg::CODE_MIN) begin
            next_st.count = st.count - 8'h01;
         end
      end
      if (reset) begin
         next_st.div   = 10'h000;
         next_st.count = lfd_pkg::SETPOINT_RESET;
      end
   end

   always_ff @(posedge clock) begin
      st <= next_st;
   end

   assign lp.count = st.count;
endmodule : lfd_headroom_loop

/* sim/lfd_regs_monitor.sv */
// checker for the register bank: bus handshakes and failsafe timing
// assumes it is bound onto lfd_regs and shares its clock and reset
module lfd_regs_monitor (
   input wire logic        clock,
   input wire logic        reset,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   input wire logic        thermal_shutdown_cond,
   input wire logic        failsafe_out_n
);
   timeunit 1ns;
   timeprecision 100ps;
   // ---------------------------------------------------------------
   // handshake and failsafe properties
   // ---------------------------------------------------------------
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   sequence s_wr_take;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // shutdown must reach the pin within the three-edge sync path
   sequence s_tsd_held;
      thermal_shutdown_cond [*5];
   endsequence
   chk_write_answer: assert property (s_wr_take |-> ##2 s_axi_bvalid)
      else $error("write response late");
   chk_read_answer: assert property
      (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data late");
   chk_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready
      |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   chk_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
      |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   chk_w_refused: assert property
      (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   chk_tsd_failsafe: assert property (s_tsd_held |-> !failsafe_out_n)
      else $error("shutdown did not pull failsafe low");
   chk_release_high: assert property ($fell(reset) |-> failsafe_out_n)
      else $error("failsafe low after reset");
endmodule : lfd_regs_monitor

bind lfd_regs lfd_regs_monitor mon_u (.*);

/* sim/lfd_regs_tb.sv */
// self-checking bench for the fault, dimming and headroom registers
// assumes lfd_regs with its bound checker and the lfd_pkg constants
module lfd_regs_tb;
   timeunit 1ns;
   timeprecision 100ps;
   // ---------------------------------------------------------------
   // stimulus and observed signals
   // ---------------------------------------------------------------
   logic        clock, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, overtemp_warning_cond;
   logic        thermal_shutdown_cond, current_set_short_cond, enable_pin;
   logic        current_set_open_cond, headroom_low, headroom_high;
   logic        otp_address_page_bit;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, otp_setpoint_code, otp_suffix;
   logic [31:0] s_axi_wdata, d, v;
   logic [15:0] channel_short_cond;
   logic [3:0]  s_axi_wstrb;
   logic [2:0]  otp_low_band, otp_high_band;
   logic [1:0]  r;
   wire logic   s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire logic   s_axi_rvalid, failsafe_out_n;
   wire logic [1:0]   s_axi_bresp, s_axi_rresp;
   wire logic [31:0]  s_axi_rdata;
   wire logic [191:0] duty_value;
   wire logic [95:0]  current_level_value;
   int          mismatches, n_checks, seed, k;

   lfd_regs dut_u (.*);

   // 100 MHz clock
   initial begin
      clock = 0;
      forever #5 clock = ~clock;
   end

   task automatic ck(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask : ck
   task automatic ckf(input logic e);
      ck(32'(failsafe_out_n), 32'(e));
   endtask : ckf
   task automatic wt(input int n);
      repeat (n) @(posedge clock);
   endtask : wt
   // aw and w offered together, each dropped once taken
   task automatic wr(input logic [5:0] i, input logic [31:0] dv);
      logic a = 0;
      logic w = 0;
      @(posedge clock);
      {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {i, 2'h0, dv, 4'hF};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
      do begin
         @(posedge clock);
         a = a | s_axi_awready;
         w = w | s_axi_wready;
         if (a) s_axi_awvalid <= 0;
         if (w) s_axi_wvalid <= 0;
      end while (!(a && w));
      do @(posedge clock); while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 0;
   endtask : wr
   task automatic rc(input logic [5:0] i, input logic [31:0] e,
                     input logic [1:0] er = 2'h0,
                     input logic [31:0] m = '1);
      @(posedge clock);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {i, 2'h0, 2'h3};
      do @(posedge clock); while (!s_axi_arready);
      s_axi_arvalid <= 0;
      do @(posedge clock); while (!s_axi_rvalid);
      d = s_axi_rdata;
      s_axi_rready <= 0;
      ck(d & m, e);
      ck(32'(s_axi_rresp), 32'(er));
   endtask : rc
   // flag bit for each protection source, warning first
   function automatic logic [31:0] pmask(input int n);
      return 32'h1 << (n == 0 ? 14 : n == 1 ? 10 : n == 2 ? 13 : 12);
   endfunction : pmask
   task automatic end_of_test();
      if (mismatches == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : end_of_test

   // main sequence; codes kept low so two or three raises never hit the clamp
   initial begin
      seed = 9;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = 4'h0;
      {s_axi_rready, overtemp_warning_cond, thermal_shutdown_cond} = 3'h0;
      {current_set_short_cond, current_set_open_cond, enable_pin} = 3'h1;
      {headroom_low, headroom_high, channel_short_cond} = 18'h00000;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
      otp_setpoint_code = 8'(14 + {$random(seed)} % 180);
      {otp_suffix, otp_low_band, otp_high_band} = 14'($random(seed));
      otp_address_page_bit = 1'($random(seed));
      reset = 1;
      wt(2);
      reset <= 0;
      wt(3);
      rc(lfd_pkg::IDX_SHORT, 32'h0);
      rc(lfd_pkg::IDX_PROT, 32'h0);
      v = {16'h0, otp_setpoint_code, otp_setpoint_code};
      rc(lfd_pkg::IDX_SETPOINT, v);
      wr(lfd_pkg::IDX_BAND, 32'hFFFFFFFF);
      ck(32'(r), 32'h0);
      v = {16'h0, 8'h25, otp_low_band, otp_high_band, 2'h1};
      rc(lfd_pkg::IDX_BAND, v);
      rc(lfd_pkg::IDX_SUFFIX, {24'h0, otp_suffix});
      v = {25'h0, otp_address_page_bit, 6'h0};
      rc(lfd_pkg::IDX_PAGE, v);
      rc(6'h3F, 32'h0, lfd_pkg::RESP_SLVERR);
      for (k = 0; k < 16; k++) begin
         rc(lfd_pkg::IDX_DUTY0 + 6'(k), 32'h00000FFF);
         rc(lfd_pkg::IDX_LEVEL0 + 6'(k), 32'h00000020);
         v = $random(seed);
         wr(lfd_pkg::IDX_DUTY0 + 6'(k), v);
         wr(lfd_pkg::IDX_LEVEL0 + 6'(k), ~v);
         rc(lfd_pkg::IDX_DUTY0 + 6'(k), v & 32'h00000FFF);
         rc(lfd_pkg::IDX_LEVEL0 + 6'(k), ~v & 32'h0000003F);
         ck(32'(duty_value[12*k +: 12]), v & 32'h00000FFF);
         ck(32'(current_level_value[6*k +: 6]), ~v & 32'h3F);
      end
      // latch-off, then hiccup, then masked; both end channels set
      v = {16'h0, 16'($random(seed)) | 16'h8001};
      for (k = 0; k < 3; k++) begin
         wr(lfd_pkg::IDX_CTRL, k == 0 ? 32'h4002 : k == 1 ? 32'h2 : 32'hC082);
         channel_short_cond <= v[15:0];
         overtemp_warning_cond <= k == 2;
         wt(6);
         ckf(k == 2);
         if (k == 1) rc(lfd_pkg::IDX_SHORT, v);
         {channel_short_cond, overtemp_warning_cond} <= 17'h0;
         wt(6);
         ckf(k != 0);
         rc(lfd_pkg::IDX_SHORT, v);
         wt(3);
         ckf(1);
         rc(lfd_pkg::IDX_SHORT, 32'h0);
      end
      rc(lfd_pkg::IDX_PROT, 32'h00004000);
      wr(lfd_pkg::IDX_CTRL, 32'h00004002);
      for (k = 0; k < 4; k++) begin
         {overtemp_warning_cond, thermal_shutdown_cond,
          current_set_short_cond, current_set_open_cond} <= 4'h8 >> k;
         wt(6);
         ckf(0);
         {overtemp_warning_cond, thermal_shutdown_cond} <= 2'h0;
         {current_set_short_cond, current_set_open_cond} <= 2'h0;
         wt(4);
         rc(lfd_pkg::IDX_PROT, pmask(k));
         rc(lfd_pkg::IDX_PROT, 32'h0);
         wt(3);
         ckf(k < 2);
         enable_pin <= 0;
         wt(5);
         ckf(1);
         enable_pin <= 1;
      end
      headroom_low <= 1;
      wt(2500);
      headroom_low <= 0;
      rc(lfd_pkg::IDX_SETPOINT, 32'h0, 2'h0, 32'hFFFF0000);
      ck(32'(d[15:8]), 32'(otp_setpoint_code));
      ck(32'(d[7:0] > otp_setpoint_code), 32'h1);
      v = d;
      headroom_high <= 1;
      wt(2500);
      headroom_high <= 0;
      rc(lfd_pkg::IDX_SETPOINT, 32'h0, 2'h0, 32'hFFFF0000);
      ck(32'(d[7:0] < v[7:0]), 32'h1);
      end_of_test();
   end

   // watchdog, well past the run length
   initial begin
      #200000;
      mismatches++;
      end_of_test();
   end
endmodule : lfd_regs_tb
